// ===== logic/swl_link.sv
`timescale 1ns/100ps
// Functional notes
// [R1] host holds line high 2 us first
// [R2] host ends stream with 2-360 us low
// [R3] short high then longer low decodes zero; the code decodes zero from a longer low followed by a short high
// [R4] short low then longer high decodes one
// [R5] acknowledge pull only when requested
// [R6] host supplies pull-up, reads low as ack
// [R7] ack low within 2 us, released by 512
// [R8] classify bits by comparing phase lengths
// [R9] address byte then data byte with fields
// [R10] host selects serial mode with long low
// [R11] accept 1.7 to 160 kbit/s unconfigured; default limits (180 + 360 us) accept 1.85 kbit/s at slowest
module swl_link
    import swl_pkg::*;
#(
    parameter int         SHORT_CYC = SHORT_MAX_CYC, // longest short phase
    parameter int         LONG_CYC  = LONG_MAX_CYC,  // longest long phase
    parameter int         ACK_CYC   = ACK_MAX_CYC,   // ack hold length
    parameter logic [7:0] DEV_ADDR  = 8'hA5, // arbitrary device address
    parameter logic [1:0] SUB_ADDR  = 2'h0   // arbitrary sub-address
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // control line, open drain
    input  wire logic       line_i,
    output logic            line_o,
    output logic            line_oe_o,
    // decoded stream
    output swl_frame_t      frame_o,
    output logic            frame_ok_o,
    output logic            frame_err_o
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (LONG_CYC >= (1 << CNT_W) - 1 || SHORT_CYC < PHASE_MIN_CYC ||
        LONG_CYC < 2 * SHORT_CYC || ACK_CYC > ACK_MAX_CYC ||
        ACK_CYC < 1 || EOS_MAX_CYC > LONG_MAX_CYC) begin : g_bad
        $error("swl_link: timing parameters out of range");
    end

    localparam logic [CNT_W-1:0] MIN_C   = CNT_W'(PHASE_MIN_CYC);
    localparam logic [CNT_W-1:0] SHORT_C = CNT_W'(SHORT_CYC);
    localparam logic [CNT_W-1:0] LONG_C  = CNT_W'(LONG_CYC);
    localparam logic [CNT_W-1:0] START_C = CNT_W'(START_CYC);
    localparam logic [CNT_W-1:0] EOSMN_C = CNT_W'(EOS_MIN_CYC);
    localparam logic [CNT_W-1:0] ACK_C   = CNT_W'(ACK_CYC);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    swl_state_t        st;        // registered state
    swl_state_t        next_st;   // next state
    logic              rise;      // line went high this cycle
    logic              fall;      // line went low this cycle
    logic [1:0]        cls;       // {valid, bit} of finished bit
    logic [CNT_W-1:0]  cnt_inc;   // saturating phase count + 1

    // ratio test: longer phase at least twice the shorter one, the
    // shorter within its window; no absolute bit period is assumed
    function automatic logic [1:0] classify(
        input logic [CNT_W-1:0] lo,
        input logic [CNT_W-1:0] hi);
        logic short_lo;
        logic short_hi;
        short_lo = (lo >= MIN_C) && (lo <= SHORT_C);
        short_hi = (hi >= MIN_C) && (hi <= SHORT_C);
        if (short_hi && ({1'b0, lo} >= {hi, 1'b0}) && lo <= LONG_C)
            classify = 2'b10;                            // [R3] [R8]
        else if (short_lo && ({1'b0, hi} >= {lo, 1'b0}) && hi <= LONG_C)
            classify = 2'b11;                            // [R4] [R8]
        else
            classify = 2'b00;
    endfunction

    // edge detection on the previous line sample
    assign rise    = line_i & ~st.line_q;
    assign fall    = ~line_i & st.line_q;
    assign cls     = classify(st.low_len, st.cnt);
    assign cnt_inc = (st.cnt == '1) ? st.cnt : st.cnt + 1'b1;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st        = st;
        next_st.ok     = 1'b0;
        next_st.err    = 1'b0;
        next_st.line_q = line_i;
        case (st.fsm)
            // count idle high time; a fall after enough of it starts
            S_IDLE: begin
                if (fall && st.cnt >= START_C) begin
                    next_st.fsm  = S_LOW;
                    next_st.cnt  = CNT_W'(1);
                    next_st.bits = '0;
                end else if (line_i) begin
                    next_st.cnt = cnt_inc;
                end else begin
                    next_st.cnt = '0;
                end
            end
            // low phase: remember its length at the rise
            S_LOW: begin
                if (rise) begin
                    next_st.low_len = st.cnt;
                    next_st.fsm     = S_HIGH;
                    next_st.cnt     = CNT_W'(1);
                end else if (st.cnt >= LONG_C) begin  // [R11]
                    next_st.err = 1'b1;
                    next_st.fsm = S_IDLE;
                    next_st.cnt = '0;
                end else begin
                    next_st.cnt = cnt_inc;
                end
            end
            // high phase: the fall closes the bit and classifies it
            S_HIGH: begin
                if (fall) begin
                    next_st.cnt = CNT_W'(1);
                    if (cls[1]) begin
                        next_st.shreg = {st.shreg[14:0], cls[0]}; // [R3] [R4]
                        next_st.bits  = st.bits + 1'b1;
                        next_st.fsm   = (st.bits == 4'(STREAM_BITS - 1))
                                        ? S_EOS : S_LOW;   // [R9]
                    end else begin
                        next_st.err = 1'b1;                // [R8]
                        next_st.fsm = S_IDLE;
                        next_st.cnt = '0;
                    end
                end else if (st.cnt >= LONG_C) begin       // [R11]
                    next_st.err = 1'b1;
                    next_st.fsm = S_IDLE;
                    next_st.cnt = '0;
                end else begin
                    next_st.cnt = cnt_inc;
                end
            end
            // end-of-stream low; the rise after it completes the frame
            S_EOS: begin
                if (rise) begin
                    next_st.cnt = '0;
                    next_st.fsm = S_IDLE;
                    if (st.cnt < EOSMN_C) begin
                        next_st.err = 1'b1;
                    end else if (st.shreg[15:8] == DEV_ADDR &&
                                 st.shreg[6:5] == SUB_ADDR) begin // [R9]
                        next_st.frame = st.shreg[7:0];
                        next_st.ok    = 1'b1;
                        if (st.shreg[ACK_REQ_POS]) begin   // [R5]
                            next_st.fsm = S_ACK;           // [R7]
                            next_st.cnt = CNT_W'(1);
                        end
                    end
                    // another address: not ours, stay silent
                end else if (st.cnt >= LONG_C) begin
                    next_st.err = 1'b1;
                    next_st.fsm = S_IDLE;
                    next_st.cnt = '0;
                end else begin
                    next_st.cnt = cnt_inc;
                end
            end
            // hold the line low for a fixed count, then let go
            S_ACK: begin
                if (st.cnt >= ACK_C) begin                 // [R7]
                    next_st.fsm = S_IDLE;
                    next_st.cnt = '0;
                end else begin
                    next_st.cnt = cnt_inc;
                end
            end
            default: begin
                next_st = ST_RESET;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // open drain: only ever pulls low, enable comes straight from state
    assign line_o      = 1'b0;                             // [R5]
    assign line_oe_o   = (st.fsm == S_ACK);                // [R5] [R7]
    assign frame_o     = st.frame;
    assign frame_ok_o  = st.ok;
    assign frame_err_o = st.err;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_ack_only_req: assert property (                      // [R5]
        line_oe_o |-> frame_o.ack_req)
        else $error("ack driven without request");

    a_ack_fast: assert property (                          // [R7]
        frame_ok_o && frame_o.ack_req |-> line_oe_o)
        else $error("ack not valid at stream accept");

    a_ack_release: assert property (                       // [R7]
        $fell(line_oe_o) |-> $past(st.cnt) == ACK_C)
        else $error("ack held wrong length");

    a_ack_bound: assert property (                         // [R7]
        line_oe_o |-> st.cnt <= ACK_C)
        else $error("ack count past limit");

    a_zero_decode: assert property (                       // [R3]
        st.fsm == S_HIGH && fall && st.cnt >= MIN_C &&
        st.cnt <= SHORT_C && {1'b0, st.low_len} >= {st.cnt, 1'b0}
        |=> st.shreg[0] == 1'b0 && !frame_err_o)
        else $error("zero bit misdecoded");

    a_one_decode: assert property (                        // [R4]
        st.fsm == S_HIGH && fall && st.low_len >= MIN_C &&
        st.low_len <= SHORT_C && {1'b0, st.cnt} >= {st.low_len, 1'b0}
        |=> st.shreg[0] == 1'b1 && !frame_err_o)
        else $error("one bit misdecoded");

    // neither phase reaches twice the other: no legal bit fits
    a_ratio_reject: assert property (                      // [R8]
        st.fsm == S_HIGH && fall &&
        {1'b0, st.low_len} < {st.cnt, 1'b0} &&
        {1'b0, st.cnt} < {st.low_len, 1'b0}
        |=> frame_err_o && st.fsm == S_IDLE)
        else $error("bad ratio not rejected");

    a_addr_match: assert property (                        // [R9]
        frame_ok_o |-> $past(st.shreg[15:8]) == DEV_ADDR &&
        frame_o == $past(st.shreg[7:0]))
        else $error("frame accepted with wrong address");

    a_phase_bound: assert property (                       // [R11]
        st.fsm inside {S_LOW, S_HIGH, S_EOS} |-> st.cnt <= LONG_C)
        else $error("phase counter beyond longest phase");

    c_ack_frame:   cover property (frame_ok_o && frame_o.ack_req);
    c_quiet_frame: cover property (frame_ok_o && !frame_o.ack_req);
    c_bad_stream:  cover property (frame_err_o);
    c_ack_done:    cover property ($fell(line_oe_o));

endmodule

// ===== logic/swl_pkg.sv
package swl_pkg;

    // ----------------------------------------------------------------
    // timebase
    // ----------------------------------------------------------------
    localparam int CLK_MHZ         = 200;  // core clock rate in MHz

    // ----------------------------------------------------------------
    // link timing in microseconds, as printed
    // ----------------------------------------------------------------
    localparam int T_START_MIN_US  = 2;    // idle high before a stream
    localparam int T_PHASE_MIN_US  = 2;    // shortest bit phase
    localparam int T_SHORT_MAX_US  = 180;  // longest short phase
    localparam int T_LONG_MAX_US   = 360;  // longest long phase
    localparam int T_EOS_MIN_US    = 2;    // end-of-stream low, least
    localparam int T_EOS_MAX_US    = 360;  // end-of-stream low, most
    localparam int T_ACK_VALID_US  = 2;    // ack low valid within
    localparam int T_ACK_MAX_US    = 512;  // ack released within

    // ----------------------------------------------------------------
    // derived cycle counts (exact at whole-MHz rates)
    // ----------------------------------------------------------------
    localparam int START_CYC       = T_START_MIN_US * CLK_MHZ;
    localparam int PHASE_MIN_CYC   = T_PHASE_MIN_US * CLK_MHZ;
    localparam int SHORT_MAX_CYC   = T_SHORT_MAX_US * CLK_MHZ;
    localparam int LONG_MAX_CYC    = T_LONG_MAX_US * CLK_MHZ;
    localparam int EOS_MIN_CYC     = T_EOS_MIN_US * CLK_MHZ;
    localparam int EOS_MAX_CYC     = T_EOS_MAX_US * CLK_MHZ;
    localparam int ACK_VALID_CYC   = T_ACK_VALID_US * CLK_MHZ;
    localparam int ACK_MAX_CYC     = T_ACK_MAX_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // stream layout
    // ----------------------------------------------------------------
    localparam int CNT_W           = 18;   // phase counter width
    localparam int STREAM_BITS     = 16;   // address byte + data byte
    localparam int ACK_REQ_POS     = 7;    // ack_request_bit in data
    localparam int SUB_ADDR_LSB    = 5;    // two address bits
    localparam int SETPT_W         = 5;    // setpoint field width
    localparam logic [4:0] SETPT_RESET = 5'h1F;  // full scale

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE,   // waiting for start interval and first fall
        S_LOW,    // low phase of a bit
        S_HIGH,   // high phase of a bit
        S_EOS,    // end-of-stream low
        S_ACK     // driving acknowledge
    } swl_fsm_t;

    typedef struct packed {
        logic              ack_req;   // ack_request_bit as received
        logic [1:0]        sub_addr;  // address bits of data byte
        logic [SETPT_W-1:0] setpoint; // feedback_node setpoint code
    } swl_frame_t;

    typedef struct packed {
        swl_fsm_t          fsm;       // link state
        logic [CNT_W-1:0]  cnt;       // cycles in current phase
        logic [CNT_W-1:0]  low_len;   // length of last low phase
        logic [3:0]        bits;      // bits received so far
        logic [15:0]       shreg;     // received stream, msb first
        logic              line_q;    // line one cycle back
        swl_frame_t        frame;     // last accepted data byte
        logic              ok;        // accepted-stream pulse
        logic              err;       // malformed-stream pulse
    } swl_state_t;

    localparam swl_state_t ST_RESET = '{
        fsm: S_IDLE, cnt: '0, low_len: '0, bits: '0, shreg: '0,
        line_q: 1'b1,
        frame: '{ack_req: 1'b0, sub_addr: 2'h0, setpoint: SETPT_RESET},
        ok: 1'b0, err: 1'b0};

endpackage

// ===== testbench/swl_host_model.sv
`timescale 1ns/100ps
module swl_host_model
    import swl_pkg::*;
(
    // clock
    input  wire logic core_clk_i,
    // device side of the open-drain pin
    input  wire logic pin_val_i,
    input  wire logic pin_oe_i,
    // resolved line and acknowledge as the host reads it
    output logic      line_o,
    output logic      ack_seen_o
);
    logic host_low;  // host pulls the line low

    initial host_low = 1'b0;

    // --------------------------------------------------------------
    // wire resolution
    // --------------------------------------------------------------
    // pull-up holds the line high unless a party pulls it low
    assign line_o     = ~(host_low | (pin_oe_i & ~pin_val_i));
    // low while the host is released means the device acknowledges
    assign ack_seen_o = ~line_o & ~host_low;

    // level for n cycles; called at a falling edge
    task automatic hold(input logic lvl, input int n);
        host_low = ~lvl;
        repeat (n) @(negedge core_clk_i);
    endtask

    // start, nb bits msb first, then end-of-stream low
    task automatic send(input logic [15:0] s, input int nb, input int sh,
                        input int lg, input int zl, input int eos);
        int i;
        hold(1'b1, 500);
        for (i = 15; i > 15 - nb; i--) begin
            if (s[i]) begin
                hold(1'b0, sh);
                hold(1'b1, lg);
            end else begin
                hold(1'b0, zl);
                hold(1'b1, sh);
            end
        end
        hold(1'b0, eos);
        host_low = 1'b0;
    endtask

    // mode-select pattern: high for a delay, then a long low
    task automatic select_mode(input int dly, input int det);
        hold(1'b1, dly);
        hold(1'b0, det);
        host_low = 1'b0;
    endtask
endmodule

// ===== testbench/one_wire_setpoint_link_timing_tb_top.sv
`timescale 1ns/100ps
module one_wire_setpoint_link_timing_tb_top
    import swl_pkg::*;
;
    // --------------------------------------------------------------
    // short counts keep the run small
    // --------------------------------------------------------------
    localparam int         SH_C = 1000;   // longest short phase
    localparam int         LG_C = 2000;   // longest long phase
    localparam int         AK_C = 50;     // ack hold length
    localparam logic [7:0] ADDR = 8'h5C;  // arbitrary device address

    logic       core_clk_i;   // core clock
    logic       rst_n_i;      // sync reset, active low
    logic       line_i;       // resolved line
    logic       line_o;       // pin value
    logic       line_oe_o;    // pin enable
    logic       ack_seen;     // host reads acknowledge
    swl_frame_t frame_o;      // decoded data byte
    logic       frame_ok_o;   // accepted pulse
    logic       frame_err_o;  // error pulse
    swl_frame_t last_frame;   // frame seen with ok
    logic       ack_at_ok;    // enable seen with ok
    int         fail_count;   // mismatches
    int         comparisons;  // compares made
    int         ok_cnt;       // ok pulses
    int         err_cnt;      // error pulses
    int         ack_len;      // cycles of enable high
    int         ack_host;     // cycles host saw ack
    int         ok0;          // ok count before a case
    int         err0;         // error count before a case

    swl_link #(
        .SHORT_CYC (SH_C),
        .LONG_CYC  (LG_C),
        .ACK_CYC   (AK_C),
        .DEV_ADDR  (ADDR),
        .SUB_ADDR  (2'h0)
    ) uut (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .line_i      (line_i),
        .line_o      (line_o),
        .line_oe_o   (line_oe_o),
        .frame_o     (frame_o),
        .frame_ok_o  (frame_ok_o),
        .frame_err_o (frame_err_o)
    );

    swl_host_model host (
        .core_clk_i (core_clk_i),
        .pin_val_i  (line_o),
        .pin_oe_i   (line_oe_o),
        .line_o     (line_i),
        .ack_seen_o (ack_seen)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // --------------------------------------------------------------
    // monitor, sampled mid-cycle where outputs are settled
    // --------------------------------------------------------------
    always @(negedge core_clk_i) begin
        if (frame_ok_o === 1'b1) begin
            ok_cnt++;
            last_frame = frame_o;
            ack_at_ok  = line_oe_o;
        end
        if (frame_err_o === 1'b1) err_cnt++;
        if (line_oe_o === 1'b1) ack_len++;
        if (ack_seen === 1'b1) ack_host++;
    end

    task automatic check_bit(input string w, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", w, e, g);
        end
    endtask

    task automatic check_frame(input string w, input swl_frame_t e,
                               input swl_frame_t g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic check_cnt(input string w, input int e, input int g);
        comparisons++;
        if (g != e) begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", w, e, g);
        end
    endtask

    // one stream, then idle long enough for ack and pulses to finish
    task automatic run(input logic [15:0] s, input int nb, input int sh,
                       input int lg, input int zl, input int eos);
        ok0       = ok_cnt;
        err0      = err_cnt;
        ack_len   = 0;
        ack_host  = 0;
        ack_at_ok = 1'b0;
        host.send(s, nb, sh, lg, zl, eos);
        host.hold(1'b1, 200);
    endtask

    task automatic outcome(input int eo, input int ee);
        check_cnt("ok pulses", eo, ok_cnt - ok0);
        check_cnt("err pulses", ee, err_cnt - err0);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        check_frame("frame at reset", '{1'b0, 2'h0, 5'h1F}, frame_o);
        check_bit("enable at reset", 1'b0, line_oe_o);
        check_bit("ok at reset", 1'b0, frame_ok_o);
        check_bit("err at reset", 1'b0, frame_err_o);
        $display("test reset done");
    endtask

    // shortened mode-select low in idle; this block must stay silent
    task automatic t_mode();
        ok0  = ok_cnt;
        err0 = err_cnt;
        host.select_mode(100, 1300);
        host.hold(1'b1, 100);
        outcome(0, 0);
        check_bit("idle low enable", 1'b0, line_oe_o);
        $display("test mode done");
    endtask

    task automatic t_plain();
        run({ADDR, 8'h15}, 16, 400, 800, 800, 500);
        outcome(1, 0);
        check_frame("plain frame", '{1'b0, 2'h0, 5'h15}, last_frame);
        check_cnt("no ack", 0, ack_len);
        $display("test plain done");
    endtask

    // other bit rate, shortest end-of-stream, ack requested
    task automatic t_ack();
        run({ADDR, 8'h8A}, 16, 450, 900, 1000, 400);
        outcome(1, 0);
        check_frame("ack frame", '{1'b1, 2'h0, 5'h0A}, last_frame);
        check_bit("ack with ok", 1'b1, ack_at_ok);
        check_cnt("ack length", AK_C, ack_len);
        check_cnt("ack on wire", AK_C, ack_host);
        $display("test ack done");
    endtask

    task automatic t_addr();
        run({ADDR ^ 8'h01, 8'h87}, 16, 400, 800, 800, 500);
        outcome(0, 0);
        check_frame("frame kept", '{1'b1, 2'h0, 5'h0A}, frame_o);
        check_cnt("no ack", 0, ack_len);
        $display("test address done");
    endtask

    // zero bit whose low phase is under twice its high phase
    task automatic t_ratio();
        run(16'h0000, 1, 400, 800, 600, 500);
        outcome(0, 1);
        $display("test ratio done");
    endtask

    task automatic t_eos();
        run({ADDR, 8'h95}, 16, 400, 800, 800, 100);
        outcome(0, 1);
        check_cnt("no ack", 0, ack_len);
        $display("test short end done");
    endtask

    // truncated stream followed by a low past the longest phase
    task automatic t_tmo();
        run({ADDR, 8'h00}, 2, 400, 800, 800, 2100);
        outcome(0, 1);
        $display("test timeout done");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog at 100k cycles, above the roughly 93k the cases need
    initial begin
        #500000;
        fail_count++;
        $display("watchdog expired");
        results();
    end

    initial begin
        fail_count  = 0;
        comparisons = 0;
        ok_cnt      = 0;
        err_cnt     = 0;
        ack_len     = 0;
        ack_host    = 0;
        rst_n_i     = 1'b0;
        repeat (2) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        t_reset();
        t_mode();
        t_plain();
        t_ack();
        t_addr();
        t_ratio();
        t_eos();
        t_tmo();
        results();
    end
endmodule
